// ### rrse_pkg.sv
/*
 Package for the rotate/return/sleep execute block: opcodes, phases,
 flag positions, reset values and the carrier structs.
 Assumes a core that presents one 16-bit opcode per instruction cycle.
*/
// Behaviour
// - Return pops stack, top loads program counter
// - Shadow bit set restores accumulator, flags, bank
// - Shadow bit clear leaves those registers alone
// - Return keeps pc latches untouched, and flags too unless shadow bit set
// - Rotate left through carry updates C,N,Z
// - Destination bit zero writes accumulator, else register
// - Bank bit zero selects access bank
// - Rotate left plain updates only N,Z
// - Rotate right through carry updates C,N,Z
// - Rotate right plain updates only N,Z
// - Fill ones writes FFh, flags unchanged
// - Sleep clears powerdown flag, sets timeout flag
// - Sleep clears watchdog counter and postscaler
// - Sleep then enters halted low-power state
// - Watchdog wake clears timeout flag
package rrse_pkg;
   localparam logic [15:0] RRSE_OP_RETURN_MASK = 16'hFFFE;
   localparam logic [15:0] RRSE_OP_RETURN      = 16'h0012;
   localparam logic [15:0] RRSE_OP_SLEEP       = 16'h0003;
   localparam logic [7:0]  RRSE_RRC_HI         = 8'h30;
   localparam logic [7:0]  RRSE_RLC_HI         = 8'h34;
   localparam logic [7:0]  RRSE_RRN_HI         = 8'h40;
   localparam logic [7:0]  RRSE_RLN_HI         = 8'h44;
   localparam logic [7:0]  RRSE_FILL_HI        = 8'h68;
   localparam logic [7:0]  RRSE_ROT_MASK       = 8'hFC;
   localparam logic [7:0]  RRSE_FILL_MASK      = 8'hFE;
   localparam logic [7:0]  RRSE_ONES           = 8'hFF;
   localparam int          RRSE_BIT_SHADOW     = 0;
   localparam int          RRSE_BIT_BANK       = 8;
   localparam int          RRSE_BIT_DEST       = 9;
   localparam int          RRSE_FLAG_C         = 0;
   localparam int          RRSE_FLAG_Z         = 2;
   localparam int          RRSE_FLAG_N         = 4;
   localparam logic [7:0]  RRSE_STATUS_RST     = 8'h00;
   localparam logic [7:0]  RRSE_ACC_RST        = 8'h00;
   localparam logic [3:0]  RRSE_BANK_RST       = 4'h0;
   localparam logic [3:0]  RRSE_ACCESS_BANK_LO = 4'h0;
   localparam logic [3:0]  RRSE_ACCESS_BANK_HI = 4'hF;
   localparam logic [7:0]  RRSE_ACCESS_SPLIT   = 8'h80;
   localparam logic [20:0] RRSE_PC_RST         = 21'h00_0000;
   localparam logic        RRSE_TO_RST         = 1'b1;
   localparam logic        RRSE_PD_RST         = 1'b1;

   typedef enum logic [1:0]
   {
      RRSE_Q1 = 2'b00,
      RRSE_Q2 = 2'b01,
      RRSE_Q3 = 2'b10,
      RRSE_Q4 = 2'b11
   } rrse_phase_t;

   typedef enum logic [2:0]
   {
      RRSE_K_NONE  = 3'b000,
      RRSE_K_RET   = 3'b001,
      RRSE_K_ROT   = 3'b010,
      RRSE_K_FILL  = 3'b011,
      RRSE_K_SLEEP = 3'b100,
      RRSE_K_WAIT  = 3'b101
   } rrse_kind_t;

   typedef struct packed
   {
      logic        wr;
      logic [11:0] addr;
      logic [7:0]  data;
   } rrse_mem_wr_t;

   typedef struct packed
   {
      logic [7:0]  acc;
      logic [7:0]  status;
      logic [3:0]  bank;
   } rrse_shadow_t;
endpackage

// ### rrse_dmem.sv
/*
 Data memory of the core: one write port, one registered read port.
 Assumes the caller holds the read address one cycle before using data.
*/
module rrse_dmem
   import rrse_pkg::*;
#(
   parameter int AW = 12
)
(
   input  wire logic          clk_sys,
   input  wire logic [AW-1:0] rd_addr,
   output logic      [7:0]    rd_data,
   input  wire rrse_mem_wr_t  wr_port
);
   logic [7:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk_sys)
   begin
      if (wr_port.wr)
      begin
         mem[wr_port.addr[AW-1:0]] <= wr_port.data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule

// ### rrse_exec.sv
/*
 Execute block for return, rotates, fill-ones and sleep.
 Assumes opcode is stable across the four quarter phases of a cycle,
 the stack top is valid when a return is presented, and the wake
 sources are synchronous single-cycle pulses from the core.
*/
module rrse_exec
   import rrse_pkg::*;
#(
   parameter int AW = 12
)
(
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic [15:0]  opcode,
   input  wire logic [20:0]  stack_top,
   input  wire rrse_shadow_t shadow_in,
   input  wire logic         wake_watchdog,
   input  wire logic         wake_other,
   output logic      [1:0]   phase,
   output logic      [20:0]  pc,
   output logic              stack_pop,
   output logic      [7:0]   working_accumulator,
   output logic      [7:0]   status_flags,
   output logic      [3:0]   bank_select_reg,
   output logic      [7:0]   pc_upper_latch,
   output logic      [7:0]   pc_high_latch,
   output logic              timeout_flag,
   output logic              powerdown_flag,
   output logic              watchdog_clear,
   output logic              sleeping,
   output logic              busy_second
);
   default clocking cb_sys @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   typedef struct packed
   {
      rrse_phase_t  ph;
      rrse_kind_t   kind;
      logic [20:0]  pc;
      logic         pop;
      logic [7:0]   acc;
      logic [7:0]   status;
      logic [3:0]   bank;
      logic [7:0]   latu;
      logic [7:0]   lath;
      logic         to_f;
      logic         pd_f;
      logic         wdt_clr;
      logic         sleep;
      logic         second;
      logic [7:0]   result;
      logic [7:0]   res_flags;
      logic [11:0]  addr;
      rrse_mem_wr_t wr;
   } rrse_state_t;

   rrse_state_t s_reg;
   rrse_state_t s_next;
   logic [7:0]  rd_data;
   logic [7:0]  hi;
   logic        cin;
   logic [7:0]  r;
   logic        cout;

   rrse_dmem #(.AW(AW)) u_mem
   (
      .clk_sys (clk_sys),
      .rd_addr (s_reg.addr[AW-1:0]),
      .rd_data (rd_data),
      .wr_port (s_reg.wr)
   );

   assign hi = opcode[15:8];

   always_comb
   begin
      s_next         = s_reg;
      s_next.pop     = 1'b0;
      s_next.wdt_clr = 1'b0;
      s_next.wr.wr   = 1'b0;
      r              = 8'h00;
      cin            = s_reg.status[RRSE_FLAG_C];
      cout           = cin;
      if (s_reg.sleep)
      begin
         if (wake_watchdog)
         begin
            s_next.sleep = 1'b0;
            s_next.to_f  = 1'b0;
         end
         else if (wake_other)
         begin
            s_next.sleep = 1'b0;
         end
      end
      else
      begin
         s_next.ph = rrse_phase_t'(s_reg.ph + 2'd1);
         case (s_reg.ph)
            RRSE_Q1:
            begin
               if (s_reg.second)
                  s_next.kind = RRSE_K_WAIT;
               else if ((opcode & RRSE_OP_RETURN_MASK) == RRSE_OP_RETURN)
                  s_next.kind = RRSE_K_RET;
               else if (opcode == RRSE_OP_SLEEP)
                  s_next.kind = RRSE_K_SLEEP;
               else if ((hi & RRSE_ROT_MASK) == RRSE_RRC_HI ||
                        (hi & RRSE_ROT_MASK) == RRSE_RLC_HI ||
                        (hi & RRSE_ROT_MASK) == RRSE_RRN_HI ||
                        (hi & RRSE_ROT_MASK) == RRSE_RLN_HI)
                  s_next.kind = RRSE_K_ROT;
               else if ((hi & RRSE_FILL_MASK) == RRSE_FILL_HI)
                  s_next.kind = RRSE_K_FILL;
               else
                  s_next.kind = RRSE_K_NONE;
               if (!opcode[RRSE_BIT_BANK])
                  s_next.addr = {(opcode[7:0] < RRSE_ACCESS_SPLIT) ?
                                 RRSE_ACCESS_BANK_LO : RRSE_ACCESS_BANK_HI,
                                 opcode[7:0]};
               else
                  s_next.addr = {s_reg.bank, opcode[7:0]};
            end
            RRSE_Q2:
            begin
            end
            RRSE_Q3:
            begin
               s_next.res_flags = s_reg.status;
               case (hi & RRSE_ROT_MASK)
                  RRSE_RLC_HI:
                  begin
                     r    = {rd_data[6:0], cin};
                     cout = rd_data[7];
                  end
                  RRSE_RLN_HI: r = {rd_data[6:0], rd_data[7]};
                  RRSE_RRC_HI:
                  begin
                     r    = {cin, rd_data[7:1]};
                     cout = rd_data[0];
                  end
                  RRSE_RRN_HI: r = {rd_data[0], rd_data[7:1]};
                  default:     r = RRSE_ONES;
               endcase
               s_next.result = r;
               if (s_reg.kind == RRSE_K_ROT)
               begin
                  s_next.res_flags[RRSE_FLAG_N] = r[7];
                  s_next.res_flags[RRSE_FLAG_Z] = (r == 8'h00);
                  if (!hi[6])
                     s_next.res_flags[RRSE_FLAG_C] = cout;
               end
               else if (s_reg.kind == RRSE_K_SLEEP)
               begin
                  s_next.wdt_clr = 1'b1;
               end
            end
            RRSE_Q4:
            begin
               s_next.second = 1'b0;
               s_next.kind   = RRSE_K_NONE;
               case (s_reg.kind)
                  RRSE_K_RET:
                  begin
                     s_next.pc     = stack_top;
                     s_next.pop    = 1'b1;
                     s_next.second = 1'b1;
                     if (opcode[RRSE_BIT_SHADOW])
                     begin
                        s_next.acc    = shadow_in.acc;
                        s_next.status = shadow_in.status;
                        s_next.bank   = shadow_in.bank;
                     end
                  end
                  RRSE_K_ROT:
                  begin
                     s_next.status = s_reg.res_flags;
                     if (!opcode[RRSE_BIT_DEST])
                        s_next.acc = s_reg.result;
                     else
                     begin
                        s_next.wr.wr   = 1'b1;
                        s_next.wr.addr = s_reg.addr;
                        s_next.wr.data = s_reg.result;
                     end
                     s_next.pc = 21'(s_reg.pc + 21'd2);
                  end
                  RRSE_K_FILL:
                  begin
                     s_next.wr.wr   = 1'b1;
                     s_next.wr.addr = s_reg.addr;
                     s_next.wr.data = RRSE_ONES;
                     s_next.pc      = 21'(s_reg.pc + 21'd2);
                  end
                  RRSE_K_SLEEP:
                  begin
                     s_next.pd_f  = 1'b0;
                     s_next.to_f  = 1'b1;
                     s_next.sleep = 1'b1;
                     s_next.pc    = 21'(s_reg.pc + 21'd2);
                  end
                  RRSE_K_WAIT: ;
                  default: s_next.pc = 21'(s_reg.pc + 21'd2);
               endcase
            end
            default: s_next.ph = RRSE_Q1;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         s_reg        <= '0;
         s_reg.ph     <= RRSE_Q1;
         s_reg.kind   <= RRSE_K_NONE;
         s_reg.pc     <= RRSE_PC_RST;
         s_reg.acc    <= RRSE_ACC_RST;
         s_reg.status <= RRSE_STATUS_RST;
         s_reg.bank   <= RRSE_BANK_RST;
         s_reg.to_f   <= RRSE_TO_RST;
         s_reg.pd_f   <= RRSE_PD_RST;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign phase               = s_reg.ph;
   assign pc                  = s_reg.pc;
   assign stack_pop           = s_reg.pop;
   assign working_accumulator = s_reg.acc;
   assign status_flags        = s_reg.status;
   assign bank_select_reg     = s_reg.bank;
   assign pc_upper_latch      = s_reg.latu;
   assign pc_high_latch       = s_reg.lath;
   assign timeout_flag        = s_reg.to_f;
   assign powerdown_flag      = s_reg.pd_f;
   assign watchdog_clear      = s_reg.wdt_clr;
   assign sleeping            = s_reg.sleep;
   assign busy_second         = s_reg.second;

   sequence seq_ret_q4;
      s_reg.ph == RRSE_Q4 && s_reg.kind == RRSE_K_RET && !s_reg.sleep;
   endsequence

   sequence seq_sleep_q4;
      s_reg.ph == RRSE_Q4 && s_reg.kind == RRSE_K_SLEEP && !s_reg.sleep;
   endsequence

   chk_ret_pops_pc: assert property (
      seq_ret_q4 |=> stack_pop && pc == $past(stack_top))
      else $error("return did not pop into pc");

   chk_ret_shadow_load: assert property (
      seq_ret_q4 and opcode[0] |=> working_accumulator == $past(shadow_in.acc)
         && status_flags == $past(shadow_in.status)
         && bank_select_reg == $past(shadow_in.bank))
      else $error("shadow restore missing");

   chk_ret_no_shadow: assert property (
      seq_ret_q4 and !opcode[0] |=> $stable(working_accumulator)
         && $stable(status_flags) && $stable(bank_select_reg))
      else $error("return changed registers without shadow");

   chk_ret_latches_kept: assert property (
      seq_ret_q4 |=> $stable(pc_upper_latch) && $stable(pc_high_latch))
      else $error("return touched pc latches");

   chk_sleep_flags: assert property (
      seq_sleep_q4 |=> !powerdown_flag && timeout_flag && sleeping)
      else $error("sleep flags wrong");

   chk_sleep_wdt_clr: assert property (
      seq_sleep_q4 |-> watchdog_clear)
      else $error("watchdog not cleared before sleep");

   chk_sleep_holds_pc: assert property (
      sleeping && !wake_watchdog && !wake_other |=> $stable(pc) && sleeping)
      else $error("core ran while asleep");

   chk_wdt_wake_to: assert property (
      sleeping && wake_watchdog |=> !timeout_flag && !sleeping)
      else $error("watchdog wake kept timeout flag");

   chk_ret_two_cycles: assert property (
      seq_ret_q4 |=> busy_second ##4 $stable(pc) && !busy_second)
      else $error("return second cycle not idle");

   chk_fill_flags: assert property (
      s_reg.ph == RRSE_Q4 && s_reg.kind == RRSE_K_FILL && !s_reg.sleep
         |=> $stable(status_flags) && s_reg.wr.data == RRSE_ONES)
      else $error("fill ones wrong");
endmodule

// ### rrse_exec_tb.sv
/*
 Bench for rrse_exec: a random mix of fill, rotate and return
 instructions, then sleep with both wake sources.
 Assumes results land on the outputs at the edge that ends Q4.
*/
module rrse_exec_tb
   import rrse_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed
   {
      logic [20:0] pc;
      logic [7:0]  acc;
      logic [7:0]  st;
      logic [3:0]  bank;
      logic        pop;
      logic        busy;
      logic        to;
      logic        pd;
   } rrse_note_t;
   logic         clk_sys = 1'b0;
   logic         rst = 1'b1;
   logic [15:0]  opcode = 16'h0000;
   logic [20:0]  stack_top = 21'h00_0000;
   rrse_shadow_t shadow_in = '0;
   logic         wake_watchdog = 1'b0;
   logic         wake_other = 1'b0;
   logic [1:0]   phase;
   logic [20:0]  pc;
   logic         stack_pop;
   logic [7:0]   working_accumulator;
   logic [7:0]   status_flags;
   logic [3:0]   bank_select_reg;
   logic [7:0]   pc_upper_latch;
   logic [7:0]   pc_high_latch;
   logic         timeout_flag;
   logic         powerdown_flag;
   logic         watchdog_clear;
   logic         sleeping;
   logic         busy_second;
   int           n_mismatch = 0;
   int           checks = 0;
   integer       seed = 21;
   logic         watch = 1'b1;
   logic [20:0]  pc_prev = 21'h00_0000;
   rrse_note_t   notes[$];
   rrse_note_t   mdl = '{pc: 21'h00_0002, to: 1'b1, pd: 1'b1, default: '0};
   logic [7:0]   mem [logic [11:0]];

   rrse_exec #(.AW(12)) u_dut
   (
      .clk_sys(clk_sys), .rst(rst), .opcode(opcode),
      .stack_top(stack_top), .shadow_in(shadow_in),
      .wake_watchdog(wake_watchdog), .wake_other(wake_other),
      .phase(phase), .pc(pc), .stack_pop(stack_pop),
      .working_accumulator(working_accumulator),
      .status_flags(status_flags), .bank_select_reg(bank_select_reg),
      .pc_upper_latch(pc_upper_latch), .pc_high_latch(pc_high_latch),
      .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag),
      .watchdog_clear(watchdog_clear), .sleeping(sleeping),
      .busy_second(busy_second)
   );

   initial forever #2.5 clk_sys = ~clk_sys;

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h",
                  $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      if (notes.size() != 0)
         n_mismatch++;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Result watcher: one note per program counter change
   always @(negedge clk_sys)
   begin
      rrse_note_t  e;
      logic [19:0] s;
      if (watch && pc !== pc_prev)
      begin
         if (notes.size() == 0)
            check(pc, pc_prev);
         else
         begin
            e = notes.pop_front();
            s = {working_accumulator, status_flags, bank_select_reg};
            check(pc, e.pc);
            check(s[19:12], e.acc);
            check(s, {e.acc, e.st, e.bank});
            check({stack_pop, busy_second}, {e.pop, e.busy});
            check({timeout_flag, powerdown_flag}, {e.to, e.pd});
            check({pc_upper_latch, pc_high_latch}, 16'h0000);
         end
      end
      pc_prev = pc;
   end

   task automatic issue(input logic [15:0] op, input int n);
      opcode <= op;
      notes.push_back(mdl);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic sync();
      int k;
      for (k = 0; k < 16 && phase !== 2'h3; k++)
         @(negedge clk_sys);
      check(phase, 2'h3);
      @(posedge clk_sys);
   endtask

   task automatic wait_sleep(input logic v);
      int k;
      for (k = 0; k < 16 && sleeping !== v; k++)
         @(negedge clk_sys);
      check(sleeping, v);
   endtask

   task automatic step(input int kind);
      logic [31:0]  rv;
      logic [31:0]  rw;
      logic [7:0]   f;
      logic [7:0]   v;
      logic [7:0]   r;
      logic [7:0]   hi;
      logic [11:0]  ad;
      logic [15:0]  op;
      logic [20:0]  st;
      logic         c;
      rrse_shadow_t sh;
      rv = $random(seed);
      rw = $random(seed);
      f = {rv[2], 7'h10};
      ad = rv[0] ? {mdl.bank, f} : {f[7] ? RRSE_ACCESS_BANK_HI
                                          : RRSE_ACCESS_BANK_LO, f};
      if (kind > 0 && kind < 5 && !mem.exists(ad))
         kind = 0;
      sh = rw[19:0];
      st = {rv[31:12], 1'b0};
      if (st == mdl.pc)
         st = st ^ 21'h00_0002;
      mdl.pop = 1'b0;
      mdl.busy = 1'b0;
      mdl.pc = mdl.pc + 21'h00_0002;
      if (kind == 0)
      begin
         mem[ad] = RRSE_ONES;
         op = {RRSE_FILL_HI[7:1], rv[0], f};
      end
      else if (kind == 5)
      begin
         op = RRSE_OP_RETURN | {15'h0000, rv[1]};
         mdl.pc = st;
         mdl.pop = 1'b1;
         mdl.busy = 1'b1;
         if (rv[1])
            {mdl.acc, mdl.st, mdl.bank} = sh;
      end
      else
      begin
         v = mem[ad];
         c = mdl.st[RRSE_FLAG_C];
         case (kind)
            1: begin {c, r} = {v, c}; hi = RRSE_RLC_HI; end
            2: begin r = {v[6:0], v[7]}; hi = RRSE_RLN_HI; end
            3: begin {r, c} = {c, v}; hi = RRSE_RRC_HI; end
            default: begin r = {v[0], v[7:1]}; hi = RRSE_RRN_HI; end
         endcase
         mdl.st[RRSE_FLAG_C] = c;
         mdl.st[RRSE_FLAG_N] = r[7];
         mdl.st[RRSE_FLAG_Z] = (r == 8'h00);
         if (rv[1])
            mem[ad] = r;
         else
            mdl.acc = r;
         op = {hi[7:2], rv[1], rv[0], f};
      end
      shadow_in <= sh;
      stack_top <= st;
      issue(op, kind == 5 ? 8 : 4);
   endtask

   task automatic sleep_test();
      logic [1:0] ph;
      mdl.pc = mdl.pc + 21'h00_0002;
      {mdl.pop, mdl.busy, mdl.to, mdl.pd} = 4'h2;
      issue(RRSE_OP_SLEEP, 3);
      @(negedge clk_sys);
      check(watchdog_clear, 1'b1);
      @(negedge clk_sys);
      check({watchdog_clear, sleeping}, 2'h1);
      ph = phase;
      @(posedge clk_sys);
      watch = 1'b0;
      opcode <= 16'hFFFF;
      repeat (6) @(negedge clk_sys);
      check({phase, pc}, {ph, mdl.pc});
      @(posedge clk_sys);
      wake_watchdog <= 1'b1;
      @(posedge clk_sys);
      wake_watchdog <= 1'b0;
      wait_sleep(1'b0);
      check({timeout_flag, powerdown_flag}, 2'h0);
      $display("test watchdog wake done");
      sync();
      opcode <= RRSE_OP_SLEEP;
      wait_sleep(1'b1);
      check({timeout_flag, powerdown_flag}, 2'h2);
      @(posedge clk_sys);
      opcode <= 16'hFFFF;
      wake_other <= 1'b1;
      @(posedge clk_sys);
      wake_other <= 1'b0;
      wait_sleep(1'b0);
      check({timeout_flag, powerdown_flag}, 2'h2);
      $display("test other wake done");
   endtask

   initial
   begin
      int i;
      notes.push_back(mdl);
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      sync();
      for (i = 0; i < 60; i++)
         step(i < 6 ? i : {$random(seed)} % 6);
      $display("test instruction mix done");
      sleep_test();
      complete_run();
   end

   initial
   begin
      #50000;
      n_mismatch++;
      complete_run();
   end
endmodule
